// file: logic/fpbm_defs.svh
// Purpose: Offsets, field positions, reset values and timing counts of the flash guard block
// Assumes: 20 MHz system clock
// Notes:   Included by every design file of the block
`ifndef FPBM_DEFS_SVH
`define FPBM_DEFS_SVH

// ----------------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------------
`define FPBM_OFS_SECURITY   12'h010
`define FPBM_OFS_STATUS     12'h020
`define FPBM_OFS_GUARD      12'h030
`define FPBM_OFS_CMD        12'h040
`define FPBM_OFS_CMD_ADDR   12'h044

// ----------------------------------------------------------------------------
// Fields, keys and reset values
// ----------------------------------------------------------------------------
`define FPBM_READY_BIT      0
`define FPBM_REJECT_BIT     1
`define FPBM_SEC_KEY        32'ha74a_9d23
`define FPBM_SEC_WINDOW     5'h10
`define FPBM_SEC_RESET      1'b1
`define FPBM_GUARD_RESET    4'h0

// ----------------------------------------------------------------------------
// Memory organisation and map
// ----------------------------------------------------------------------------
`define FPBM_PAGE_LSB       7
`define FPBM_BLOCK_LSB      15
`define FPBM_FLASH_CHIP_BASE 32'h0000_0000
`define FPBM_FLASH_CHIP_LAST 32'h0001_ffff
`define FPBM_FLASH_BOOT_BASE 32'h3f80_0000
`define FPBM_FLASH_BOOT_LAST 32'h3f81_ffff
`define FPBM_ROM_LAST       32'h0000_0fff
`define FPBM_RAM_BASE       32'h2000_0000
`define FPBM_RAM_LAST       32'h2000_3fff

// ----------------------------------------------------------------------------
// Timing: times in ns, counts derived from the clock period
// ----------------------------------------------------------------------------
`define FPBM_CLK_PERIOD_NS  50
`define FPBM_PAGE_NS        1250000
`define FPBM_BLOCK_NS       100000000
`define FPBM_CHIP_NS        200000000
`define FPBM_PAGE_CYCLES    (`FPBM_PAGE_NS / `FPBM_CLK_PERIOD_NS)
`define FPBM_BLOCK_CYCLES   (`FPBM_BLOCK_NS / `FPBM_CLK_PERIOD_NS)
`define FPBM_CHIP_CYCLES    (`FPBM_CHIP_NS / `FPBM_CLK_PERIOD_NS)

`endif

// file: logic/fpbm_pkg.sv
// Purpose: Types shared by the flash guard block
// Assumes: fpbm_defs.svh for all numbers
// Notes:   Command codes are the low bits of the command register
`include "fpbm_defs.svh"
package fpbm_pkg;
   typedef enum logic [2:0] {
      FPBM_CMD_NONE       = 3'h0,
      FPBM_CMD_PAGE_PROG  = 3'h1,
      FPBM_CMD_BLOCK_ERASE = 3'h2,
      FPBM_CMD_CHIP_ERASE = 3'h3,
      FPBM_CMD_GUARD_PROG = 3'h4,
      FPBM_CMD_GUARD_ERASE = 3'h5
   } fpbm_cmd_t;

   typedef enum logic [1:0] {
      FPBM_IDLE,
      FPBM_RUN,
      FPBM_FAILED
   } fpbm_state_t;

   // Block index of a flash offset
   function automatic logic [1:0] fpbm_block_of(input logic [16:0] ofs);
      fpbm_block_of = ofs[16:`FPBM_BLOCK_LSB];
   endfunction : fpbm_block_of
endpackage : fpbm_pkg

// file: logic/fpbm_key_gate.sv
// Purpose: Keyed update of the security enable bit
// Assumes: wr_hit pulses for one cycle per completed write to the security register
// Notes:   Partial-width writes never count
`include "fpbm_defs.svh"
module fpbm_key_gate (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        wr_hit,
   input  wire logic        wr_full,
   input  wire logic [31:0] wr_data,
   output logic             security_enable_bit
);
   import fpbm_pkg::*;

   logic [4:0] window;

   // ----------------------------------------------------------------------------
   // Unlock window and bit update
   // ----------------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         window              <= 5'h00;
         security_enable_bit <= `FPBM_SEC_RESET;
      end else if (wr_hit && wr_full && wr_data == `FPBM_SEC_KEY) begin
         window <= `FPBM_SEC_WINDOW;
      end else if (wr_hit && wr_full && window != 5'h00) begin
         security_enable_bit <= wr_data[0];
         window              <= 5'h00;
      end else if (window != 5'h00) begin
         // Late or unkeyed writes fall through and change nothing
         window <= window - 5'h01;
      end
   end
endmodule : fpbm_key_gate

// file: logic/fpbm_addr_map.sv
// Purpose: Registered CPU address decode for flash, boot ROM and RAM
// Assumes: boot_from_flash is stable after reset release
// Notes:   Selects appear one cycle after the address
`include "fpbm_defs.svh"
module fpbm_addr_map (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        boot_from_flash,
   input  wire logic [31:0] cpu_addr,
   output logic             sel_flash,
   output logic             sel_rom,
   output logic             sel_ram,
   output logic [16:0]      flash_offset,
   output logic [1:0]       flash_block
);
   import fpbm_pkg::*;

   function automatic logic in_range(input logic [31:0] a, input logic [31:0] lo, input logic [31:0] hi);
      in_range = (a >= lo) && (a <= hi);
   endfunction : in_range

   logic        hit_flash;
   logic [31:0] base;

   always_comb begin
      base      = boot_from_flash ? `FPBM_FLASH_CHIP_BASE : `FPBM_FLASH_BOOT_BASE;
      hit_flash = boot_from_flash ? in_range(cpu_addr, `FPBM_FLASH_CHIP_BASE, `FPBM_FLASH_CHIP_LAST)
                                  : in_range(cpu_addr, `FPBM_FLASH_BOOT_BASE, `FPBM_FLASH_BOOT_LAST);
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         sel_flash    <= 1'b0;
         sel_rom      <= 1'b0;
         sel_ram      <= 1'b0;
         flash_offset <= 17'h0_0000;
         flash_block  <= 2'h0;
      end else begin
         sel_flash    <= hit_flash;
         sel_rom      <= !boot_from_flash && in_range(cpu_addr, 32'h0000_0000, `FPBM_ROM_LAST);
         sel_ram      <= in_range(cpu_addr, `FPBM_RAM_BASE, `FPBM_RAM_LAST);
         flash_offset <= 17'(cpu_addr - base);
         flash_block  <= fpbm_block_of(17'(cpu_addr - base));
      end
   end
endmodule : fpbm_addr_map

// file: logic/fpbm_top.sv
// Purpose: Flash guard, security lock, boot selection and command sequencer
// Assumes: AXI4-Lite master keeps the channel rules; array reports failure on nvm_fail
// Notes:   Program and erase timing is modelled by counters, array contents live outside
//
// Our own choices: the AXI4-Lite slave port and the address map.
`include "fpbm_defs.svh"
module fpbm_top #(
   parameter int PAGE_CYCLES  = `FPBM_PAGE_CYCLES,
   parameter int BLOCK_CYCLES = `FPBM_BLOCK_CYCLES,
   parameter int CHIP_CYCLES  = `FPBM_CHIP_CYCLES
) (
   input  wire logic        clk,
   input  wire logic        rst_n,
   // AXI4-Lite slave
   input  wire logic [11:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [11:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Boot and CPU address map
   input  wire logic        boot_pin,
   input  wire logic [31:0] cpu_addr,
   output logic             boot_rom_mode,
   output logic             sel_flash,
   output logic             sel_rom,
   output logic             sel_ram,
   output logic [16:0]      flash_offset,
   output logic             cpu_read_allow,
   // Debug gating
   output logic             debug_disable,
   // Flash array operation port
   output logic             nvm_start,
   output fpbm_pkg::fpbm_cmd_t nvm_kind,
   output logic [16:0]      nvm_addr,
   input  wire logic        nvm_fail
);
   import fpbm_pkg::*;

   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   // ----------------------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------------------
   logic [11:0]  aw_addr;
   logic [31:0]  w_data;
   logic [3:0]   w_strb;
   logic         aw_held;
   logic         w_held;
   logic         wr_fire;
   logic         wr_full;
   logic         wr_mapped;
   logic         rd_mapped;
   logic [31:0]  rd_word;
   logic         security_enable_bit;
   logic [3:0]   block_guard_bits;
   logic         lock;
   logic         auto_operation_ready_flag;
   logic         reject;
   logic [16:0]  cmd_addr;
   fpbm_state_t  state;
   logic [22:0]  busy_count;
   fpbm_cmd_t    run_kind;
   logic [1:0]   run_guard;
   logic         cmd_hit;
   fpbm_cmd_t    cmd_code;
   logic [1:0]   cmd_block;
   logic         cmd_ok;
   fpbm_cmd_t    next_kind;
   logic [22:0]  next_count;
   logic         boot_done;
   logic         boot_from_flash;

   function automatic logic [22:0] op_cycles(input fpbm_cmd_t k);
      case (k)
         FPBM_CMD_PAGE_PROG:   op_cycles = 23'(PAGE_CYCLES);
         FPBM_CMD_BLOCK_ERASE: op_cycles = 23'(BLOCK_CYCLES);
         FPBM_CMD_CHIP_ERASE:  op_cycles = 23'(CHIP_CYCLES);
         default:              op_cycles = 23'h00_0001;
      endcase
   endfunction : op_cycles

   // ----------------------------------------------------------------------------
   // AXI4-Lite write channels
   // ----------------------------------------------------------------------------
   assign wr_fire = aw_held && w_held && !s_axi_bvalid;
   assign wr_full = (w_strb == 4'hf);

   always_comb begin
      case (aw_addr)
         `FPBM_OFS_SECURITY, `FPBM_OFS_STATUS, `FPBM_OFS_GUARD,
         `FPBM_OFS_CMD, `FPBM_OFS_CMD_ADDR: wr_mapped = 1'b1;
         default:                           wr_mapped = 1'b0;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         aw_held       <= 1'b0;
         aw_addr       <= 12'h000;
         s_axi_awready <= 1'b1;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held       <= 1'b1;
         aw_addr       <= s_axi_awaddr;
         s_axi_awready <= 1'b0;
      end else if (wr_fire) begin
         aw_held <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
         s_axi_awready <= 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         w_held       <= 1'b0;
         w_data       <= 32'h0000_0000;
         w_strb       <= 4'h0;
         s_axi_wready <= 1'b1;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held       <= 1'b1;
         w_data       <= s_axi_wdata;
         w_strb       <= s_axi_wstrb;
         s_axi_wready <= 1'b0;
      end else if (wr_fire) begin
         w_held <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
         s_axi_wready <= 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // ----------------------------------------------------------------------------
   // AXI4-Lite read channel
   // ----------------------------------------------------------------------------
   always_comb begin
      rd_mapped = 1'b1;
      case (s_axi_araddr)
         `FPBM_OFS_SECURITY: rd_word = {31'h0, security_enable_bit};
         `FPBM_OFS_STATUS:   rd_word = {30'h0, reject, auto_operation_ready_flag};
         `FPBM_OFS_GUARD:    rd_word = {28'h0, block_guard_bits};
         `FPBM_OFS_CMD:      rd_word = {29'h0, run_kind};
         `FPBM_OFS_CMD_ADDR: rd_word = {15'h0, cmd_addr};
         default: begin
            rd_word   = 32'h0000_0000;
            rd_mapped = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rdata   <= rd_word;
         s_axi_rresp   <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // ----------------------------------------------------------------------------
   // Security bit and lock
   // ----------------------------------------------------------------------------
   fpbm_key_gate u_key_gate (
      .clk                 (clk),
      .rst_n               (rst_n),
      .wr_hit              (wr_fire && aw_addr == `FPBM_OFS_SECURITY),
      .wr_full             (wr_full),
      .wr_data             (w_data),
      .security_enable_bit (security_enable_bit)
   );

   assign lock = security_enable_bit && (&block_guard_bits);

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         debug_disable  <= 1'b1;
         cpu_read_allow <= 1'b0;
      end else begin
         debug_disable  <= lock;
         // Reads stay open whatever the lock says
         cpu_read_allow <= 1'b1;
      end
   end

   // ----------------------------------------------------------------------------
   // Command decode and admission
   // ----------------------------------------------------------------------------
   assign cmd_hit   = wr_fire && wr_full && aw_addr == `FPBM_OFS_CMD;
   assign cmd_code  = fpbm_cmd_t'(w_data[2:0]);
   assign cmd_block = fpbm_block_of(cmd_addr);

   always_comb begin
      cmd_ok    = 1'b0;
      next_kind = cmd_code;
      if (lock) begin
         // Any guard-erase try under lock becomes a full wipe
         cmd_ok    = (cmd_code == FPBM_CMD_GUARD_ERASE);
         next_kind = FPBM_CMD_CHIP_ERASE;
      end else begin
         case (cmd_code)
            FPBM_CMD_PAGE_PROG, FPBM_CMD_BLOCK_ERASE: cmd_ok = !block_guard_bits[cmd_block];
            FPBM_CMD_CHIP_ERASE:                      cmd_ok = !(|block_guard_bits);
            FPBM_CMD_GUARD_PROG, FPBM_CMD_GUARD_ERASE: cmd_ok = 1'b1;
            default:                                  cmd_ok = 1'b0;
         endcase
      end
      next_count = op_cycles(next_kind);
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cmd_addr <= 17'h0_0000;
      end else if (wr_fire && wr_full && aw_addr == `FPBM_OFS_CMD_ADDR) begin
         cmd_addr <= w_data[16:0];
      end
   end

   // ----------------------------------------------------------------------------
   // Auto operation sequencer
   // ----------------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state      <= FPBM_IDLE;
         busy_count <= 23'h00_0000;
         run_kind   <= FPBM_CMD_NONE;
         run_guard  <= 2'h0;
         reject     <= 1'b0;
         nvm_start  <= 1'b0;
         nvm_kind   <= FPBM_CMD_NONE;
         nvm_addr   <= 17'h0_0000;
      end else begin
         nvm_start <= 1'b0;
         case (state)
            FPBM_IDLE: begin
               if (cmd_hit && cmd_ok) begin
                  state      <= FPBM_RUN;
                  busy_count <= next_count;
                  run_kind   <= next_kind;
                  run_guard  <= cmd_block;
                  reject     <= 1'b0;
                  nvm_start  <= 1'b1;
                  nvm_kind   <= next_kind;
                  // Page program works on the whole page
                  nvm_addr   <= (next_kind == FPBM_CMD_PAGE_PROG) ?
                                {cmd_addr[16:`FPBM_PAGE_LSB], 7'h00} : cmd_addr;
               end else if (cmd_hit && !lock) begin
                  reject <= 1'b1;
               end
            end
            FPBM_RUN: begin
               // Commands written while busy are dropped
               if (nvm_fail) begin
                  state <= FPBM_FAILED;
               end else if (busy_count == 23'h00_0001) begin
                  state <= FPBM_IDLE;
               end else begin
                  busy_count <= busy_count - 23'h00_0001;
               end
            end
            FPBM_FAILED: state <= FPBM_FAILED;
            default:     state <= FPBM_IDLE;
         endcase
      end
   end

   assign auto_operation_ready_flag = (state == FPBM_IDLE);

   // ----------------------------------------------------------------------------
   // Guard bits
   // ----------------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         block_guard_bits <= `FPBM_GUARD_RESET;
      end else if (state == FPBM_RUN && busy_count == 23'h00_0001 && !nvm_fail) begin
         case (run_kind)
            FPBM_CMD_GUARD_PROG:  block_guard_bits[run_guard] <= 1'b1;
            FPBM_CMD_GUARD_ERASE: block_guard_bits <= 4'h0;
            FPBM_CMD_CHIP_ERASE:  block_guard_bits <= 4'h0;
            default:              block_guard_bits <= block_guard_bits;
         endcase
      end
   end

   // ----------------------------------------------------------------------------
   // Boot selection and address map
   // ----------------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         boot_done       <= 1'b0;
         boot_from_flash <= 1'b1;
         boot_rom_mode   <= 1'b0;
      end else if (!boot_done) begin
         boot_done       <= 1'b1;
         boot_from_flash <= boot_pin;
         boot_rom_mode   <= !boot_pin;
      end
   end

   fpbm_addr_map u_addr_map (
      .clk             (clk),
      .rst_n           (rst_n),
      .boot_from_flash (boot_from_flash),
      .cpu_addr        (cpu_addr),
      .sel_flash       (sel_flash),
      .sel_rom         (sel_rom),
      .sel_ram         (sel_ram),
      .flash_offset    (flash_offset),
      .flash_block     ()
   );
endmodule : fpbm_top

// file: bench/fpbm_sva.sv
// Purpose: Port assertions for the flash guard block
// Assumes: Bound into fpbm_top, one clock domain
// Notes:   Guard bits stay internal, so the lock is only seen after reset
module fpbm_sva (
   input wire logic        clk,
   input wire logic        rst_n,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic        boot_pin,
   input wire logic [31:0] cpu_addr,
   input wire logic        boot_rom_mode,
   input wire logic        sel_flash,
   input wire logic        sel_rom,
   input wire logic        sel_ram,
   input wire logic [16:0] flash_offset,
   input wire logic        cpu_read_allow,
   input wire logic        debug_disable,
   input wire logic        nvm_start
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer missing");
   a_read_done: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
      else $error("read not closed");
   a_boot_sample: assert property ($rose(rst_n) |=> boot_rom_mode == !$past(boot_pin))
      else $error("boot mode not sampled");
   a_boot_keep: assert property (!$rose(rst_n) |=> $stable(boot_rom_mode))
      else $error("boot mode moved");
   a_rom_boot: assert property (boot_rom_mode && cpu_addr <= 32'h0000_0fff |=> sel_rom && !sel_flash)
      else $error("rom not selected");
   a_flash_boot: assert property (boot_rom_mode && cpu_addr inside {[32'h3f80_0000:32'h3f81_ffff]}
      |=> sel_flash && {15'h0000, flash_offset} == $past(cpu_addr) - 32'h3f80_0000)
      else $error("relocated flash wrong");
   a_flash_chip: assert property (!boot_rom_mode && cpu_addr <= 32'h0001_ffff
      |=> sel_flash && {15'h0000, flash_offset} == $past(cpu_addr))
      else $error("flash at zero wrong");
   a_ram_map: assert property (cpu_addr inside {[32'h2000_0000:32'h2000_3fff]} |=> sel_ram && !sel_flash)
      else $error("ram not selected");
   a_read_allow: assert property ($past(rst_n) |-> cpu_read_allow)
      else $error("cpu reads blocked");
   a_start_pulse: assert property (nvm_start |=> !nvm_start)
      else $error("start longer than a cycle");
   a_lock_reset: assert property ($rose(rst_n) |=> !debug_disable)
      else $error("locked without guards");
   c_rom: cover property (sel_rom);
   c_lock: cover property ($past(rst_n) && debug_disable);
   c_start: cover property (nvm_start);
endmodule : fpbm_sva

bind fpbm_top fpbm_sva u_sva (.*);

// file: bench/fpbm_nvm_model.sv
// Purpose: Flash array stand-in answering operation starts
// Assumes: One operation at a time
// Notes:   A commanded failure holds until reset or the next start, like a worn cell
module fpbm_nvm_model (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic nvm_start,
   input wire logic fail_cmd,
   output logic     nvm_fail = 1'b0
);
   always @(posedge clk) begin
      if (!rst_n) begin
         nvm_fail <= 1'b0;
      end else if (nvm_start) begin
         nvm_fail <= fail_cmd;
      end
   end
endmodule : fpbm_nvm_model

// file: bench/flash_protect_boot_map_tb.sv
// Purpose: Self-checking bench for the flash guard block
// Assumes: Short operation counts; the array model fails on request
// Notes:   Ports are read just after an edge, before the design updates
`include "fpbm_defs.svh"
module flash_protect_boot_map_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import fpbm_pkg::*;
   logic        clk = 1'b0, rst_n = 1'b0, boot_pin = 1'b1, fail_cmd = 1'b0;
   logic [31:0] cpu_addr = '0, s_axi_wdata = '0, rd_data, s_axi_rdata;
   logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [3:0]  s_axi_wstrb = '0;
   logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, nvm_fail;
   logic        boot_rom_mode, sel_flash, sel_rom, sel_ram, cpu_read_allow, debug_disable, nvm_start;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rd_resp;
   logic [16:0] flash_offset, nvm_addr, a_last;
   fpbm_cmd_t   nvm_kind, k_last;
   int          n_mismatch = 0, checks = 0, n_start = 0;

   fpbm_top #(.PAGE_CYCLES(6), .BLOCK_CYCLES(8), .CHIP_CYCLES(12)) dut (.*);
   fpbm_nvm_model u_nvm (.*);
   always #25 clk = ~clk;
   always @(posedge clk) begin
      if (nvm_start) begin
         n_start++;
         k_last = nvm_kind;
         a_last = nvm_addr;
      end
   end

   task automatic results;
      if (n_mismatch == 0 && checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : results
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      checks++;
      if (s !== e) begin
         n_mismatch++;
         $display("wrong value at %0t: seen %h expected %h", $time, s, e);
      end
   endtask : chk
   task automatic axw(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
      int i;
      @(posedge clk);
      {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, s};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      for (i = 0; i < 50 && !(s_axi_bvalid && s_axi_bready); i++) begin
         @(posedge clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end
      rd_resp = s_axi_bresp;
      s_axi_bready <= 1'b0;
      if (i == 50) n_mismatch++;
      if (i == 50) results();
   endtask : axw
   task automatic axr(input logic [11:0] a);
      int i;
      @(posedge clk);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      for (i = 0; i < 50 && !(s_axi_rvalid && s_axi_rready); i++) begin
         @(posedge clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end
      {rd_data, rd_resp} = {s_axi_rdata, s_axi_rresp};
      s_axi_rready <= 1'b0;
      if (i == 50) n_mismatch++;
      if (i == 50) results();
   endtask : axr
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      axr(a);
      chk(rd_data, e);
   endtask : rd
   task automatic cmd(input fpbm_cmd_t c, input logic [16:0] a, input int n, input logic [31:0] st);
      int i;
      int n0;
      n0 = n_start;
      axw(`FPBM_OFS_CMD_ADDR, {15'h0000, a}, 4'hf);
      axw(`FPBM_OFS_CMD, 32'(c), 4'hf);
      axr(`FPBM_OFS_STATUS);
      if (n == 1 && c < FPBM_CMD_GUARD_PROG) chk(rd_data, 32'h0000_0000);
      // Next command only once ready, a busy write is lost
      for (i = 0; i < 40 && rd_data[0] !== 1'b1; i++) axr(`FPBM_OFS_STATUS);
      chk(rd_data, st);
      if (i == 40 && st[0]) results();
      chk(n_start - n0, n);
   endtask : cmd
   task automatic rst(input logic p);
      {rst_n, fail_cmd, boot_pin} <= {2'h0, p};
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
   endtask : rst

   task automatic t_basic;
      rd(`FPBM_OFS_STATUS, 32'h0000_0001);
      rd(`FPBM_OFS_SECURITY, 32'h0000_0001);
      axw(`FPBM_OFS_GUARD, 32'h0000_000f, 4'hf);
      chk(rd_resp, 32'h0000_0000);
      rd(`FPBM_OFS_GUARD, 32'h0000_0000);
      axr(12'h0ff);
      chk(rd_resp, 32'h0000_0002);
      cpu_addr <= 32'h0001_fffc;
      repeat (2) @(posedge clk);
      chk({sel_flash, flash_offset}, {1'b1, 17'h1_fffc});
      cpu_addr <= 32'h2000_3ffc;
      repeat (2) @(posedge clk);
      chk({sel_ram, sel_flash}, 32'h0000_0002);
   endtask : t_basic
   task automatic t_cmds;
      cmd(FPBM_CMD_PAGE_PROG, 17'h0_80c4, 1, 32'h0000_0001);
      chk({k_last, a_last}, {FPBM_CMD_PAGE_PROG, 17'h0_8080});
      cmd(FPBM_CMD_GUARD_PROG, 17'h1_0000, 1, 32'h0000_0001);
      rd(`FPBM_OFS_GUARD, 32'h0000_0004);
      cmd(FPBM_CMD_PAGE_PROG, 17'h1_0100, 0, 32'h0000_0003);
      cmd(FPBM_CMD_CHIP_ERASE, 17'h0_0000, 0, 32'h0000_0003);
      cmd(FPBM_CMD_BLOCK_ERASE, 17'h0_0100, 1, 32'h0000_0001);
      chk(k_last, FPBM_CMD_BLOCK_ERASE);
      cmd(FPBM_CMD_GUARD_ERASE, 17'h0_0000, 1, 32'h0000_0001);
      rd(`FPBM_OFS_GUARD, 32'h0000_0000);
      cmd(FPBM_CMD_CHIP_ERASE, 17'h0_0000, 1, 32'h0000_0001);
      chk(k_last, FPBM_CMD_CHIP_ERASE);
   endtask : t_cmds
   task automatic t_secure;
      for (int i = 0; i < 4; i++) cmd(FPBM_CMD_GUARD_PROG, {2'(i), 15'h0000}, 1, 32'h0000_0001);
      rd(`FPBM_OFS_GUARD, 32'h0000_000f);
      chk({debug_disable, cpu_read_allow}, 32'h0000_0003);
      cmd(FPBM_CMD_PAGE_PROG, 17'h0_0000, 0, 32'h0000_0001);
      cmd(FPBM_CMD_GUARD_ERASE, 17'h0_0000, 1, 32'h0000_0001);
      chk(k_last, FPBM_CMD_CHIP_ERASE);
      rd(`FPBM_OFS_GUARD, 32'h0000_0000);
      chk(debug_disable, 1'b0);
   endtask : t_secure
   task automatic t_key;
      axw(`FPBM_OFS_SECURITY, 32'h0000_0000, 4'hf);
      rd(`FPBM_OFS_SECURITY, 32'h0000_0001);
      axw(`FPBM_OFS_SECURITY, `FPBM_SEC_KEY, 4'h3);
      axw(`FPBM_OFS_SECURITY, 32'h0000_0000, 4'hf);
      rd(`FPBM_OFS_SECURITY, 32'h0000_0001);
      axw(`FPBM_OFS_SECURITY, `FPBM_SEC_KEY, 4'hf);
      axw(`FPBM_OFS_SECURITY, 32'h0000_0000, 4'hf);
      rd(`FPBM_OFS_SECURITY, 32'h0000_0000);
      axw(`FPBM_OFS_SECURITY, `FPBM_SEC_KEY, 4'hf);
      repeat (20) @(posedge clk);
      axw(`FPBM_OFS_SECURITY, 32'h0000_0001, 4'hf);
      rd(`FPBM_OFS_SECURITY, 32'h0000_0000);
      for (int i = 0; i < 4; i++) cmd(FPBM_CMD_GUARD_PROG, {2'(i), 15'h0000}, 1, 32'h0000_0001);
      chk(debug_disable, 1'b0);
      cmd(FPBM_CMD_GUARD_ERASE, 17'h0_0000, 1, 32'h0000_0001);
      chk(k_last, FPBM_CMD_GUARD_ERASE);
   endtask : t_key
   task automatic t_fail_boot;
      fail_cmd <= 1'b1;
      cmd(FPBM_CMD_PAGE_PROG, 17'h0_0000, 1, 32'h0000_0000);
      rst(1'b0);
      chk(boot_rom_mode, 1'b1);
      rd(`FPBM_OFS_STATUS, 32'h0000_0001);
      cpu_addr <= 32'h3f80_0040;
      repeat (2) @(posedge clk);
      chk({sel_flash, flash_offset}, {1'b1, 17'h0_0040});
      cpu_addr <= 32'h0000_0100;
      repeat (2) @(posedge clk);
      chk({sel_rom, sel_flash}, 32'h0000_0002);
   endtask : t_fail_boot

   initial begin
      rst(1'b1);
      t_basic();
      t_cmds();
      t_secure();
      t_key();
      t_fail_boot();
      results();
   end
endmodule : flash_protect_boot_map_tb
